// File: verilog/epd_pkg.sv
package epd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned LOAD_DELAY_NS  = 100000;
  localparam int unsigned LOAD_DELAY_CYC = LOAD_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_TIME_NS   = 5000000;
  localparam int unsigned PROG_TIME_CYC  = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HS_PULSE_NS    = 100;
  localparam int unsigned HS_PULSE_CYC   =
    (HS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HS_CNT_W       = 4;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned ARR_BYTES  = 8192;
  localparam int unsigned PAGE_BYTES = 32;

  // ---------------------------------------------------------------
  // register window offsets
  // ---------------------------------------------------------------
  localparam logic [9:0] OFS_REG_MAP = 10'h000;
  localparam logic [9:0] OFS_ARR_MAP = 10'h038;
  localparam logic [9:0] OFS_PDATA_A = 10'h004;
  localparam logic [9:0] OFS_PDATA_B = 10'h005;
  localparam logic [9:0] OFS_PPIN_A  = 10'h006;
  localparam logic [9:0] OFS_PPIN_B  = 10'h007;
  localparam logic [9:0] OFS_SETUP   = 10'h008;
  localparam logic [9:0] OFS_ISR     = 10'h009;

  // ---------------------------------------------------------------
  // reset values and field layouts
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MAP_RST  = 8'h81;
  localparam logic [7:0] ARR_MAP_RST  = 8'h07;
  localparam logic [7:0] ARR_MAP_MASK = 8'h2f;
  localparam logic [7:0] SETUP_RST    = 8'h00;
  localparam logic [3:0] ISR_RST      = 4'h0;
  localparam logic [7:0] LOCK_RST     = 8'h00;
  localparam int unsigned AM_RST_POL  = 3;
  localparam int unsigned AM_ECHO     = 5;
  localparam int unsigned SU_DIR      = 0;
  localparam int unsigned SU_OD       = 2;
  localparam int unsigned SU_POL      = 4;
  localparam int unsigned SU_IEN      = 6;
  localparam int unsigned IS_EOW      = 2;
  localparam int unsigned IS_EOW_EN   = 3;

  // ---------------------------------------------------------------
  // command sequence bytes and addresses
  // ---------------------------------------------------------------
  localparam logic [12:0] CMD_ADDR1     = 13'h1555;
  localparam logic [12:0] CMD_ADDR2     = 13'h0aaa;
  localparam logic [7:0]  CMD_B1        = 8'haa;
  localparam logic [7:0]  CMD_B2        = 8'h55;
  localparam logic [7:0]  CMD_WR_EN     = 8'ha0;
  localparam logic [7:0]  CMD_EXT       = 8'h80;
  localparam logic [7:0]  CMD_GUARD_OFF = 8'h20;
  localparam logic [7:0]  CMD_LOCK      = 8'h40;
  localparam logic [7:0]  CMD_RMAP      = 8'h60;
  localparam logic [7:0]  CMD_AMAP      = 8'h70;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_LOAD = 2'b01,
    PG_PROG = 2'b11
  } epd_pgm_t;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_ONE   = 3'b001,
    SQ_TWO   = 3'b011,
    SQ_THREE = 3'b010,
    SQ_FOUR  = 3'b110
  } epd_seq_t;

  typedef enum logic [1:0] {
    ARM_NONE = 2'b00,
    ARM_LOCK = 2'b01,
    ARM_RMAP = 2'b11,
    ARM_AMAP = 2'b10
  } epd_arm_t;

endpackage : epd_pkg

// File: verilog/epd_port_if.sv
`timescale 1ns/10ps
interface epd_port_if;
  logic       dir;
  logic       open_drain;
  logic       pol;
  logic       wr;
  logic       vrst;
  logic       echo;
  logic [7:0] wdata;
  logic [7:0] echo_addr;
  logic [7:0] pins_in;
  logic       hs_in;
  logic [7:0] pdata;
  logic [7:0] pins_out;
  logic [7:0] pins_oe;
  logic       hs_out;
  logic       hs_oe;
  logic       cap_evt;

  modport ctl (output dir, open_drain, pol, wr, vrst, echo, wdata,
               output echo_addr, pins_in, hs_in,
               input  pdata, pins_out, pins_oe, hs_out, hs_oe, cap_evt);
  modport unit (input  dir, open_drain, pol, wr, vrst, echo, wdata,
                input  echo_addr, pins_in, hs_in,
                output pdata, pins_out, pins_oe, hs_out, hs_oe, cap_evt);
endinterface : epd_port_if

// File: verilog/epd_port.sv
`timescale 1ns/10ps
module epd_port
  import epd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  epd_port_if.unit pif
);

  logic [7:0]          pdata_q,  pdata_d;
  logic                prev_q,   prev_d;
  logic [HS_CNT_W-1:0] cnt_q,    cnt_d;
  logic [7:0]          out_q,    out_d;
  logic [7:0]          oe_q,     oe_d;
  logic                hs_out_q, hs_out_d;
  logic                hs_oe_q,  hs_oe_d;
  logic                cap_q,    cap_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    // strobe xor polarity: the trailing edge becomes a rising edge
    prev_d  = pif.hs_in ^ pif.pol;
    pdata_d = pdata_q;
    cap_d   = 1'b0;
    cnt_d   = cnt_q;
    if (!pif.dir && prev_d && !prev_q)
    begin
      pdata_d = pif.pins_in;
      cap_d   = 1'b1;
    end
    if (pif.dir && pif.wr)
    begin
      pdata_d = pif.wdata;
      cnt_d   = HS_CNT_W'(HS_PULSE_CYC);
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
    hs_oe_d  = pif.dir;
    hs_out_d = (cnt_d != '0) ? pif.pol : ~pif.pol;
    if (pif.echo)
    begin
      out_d = pif.echo_addr;
      oe_d  = 8'hff;
    end
    else if (pif.dir && pif.open_drain)
    begin
      out_d = 8'h00;
      oe_d  = ~pdata_d;
    end
    else if (pif.dir)
    begin
      out_d = pdata_d;
      oe_d  = 8'hff;
    end
    else
    begin
      out_d = 8'h00;
      oe_d  = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // registers, cleared by either reset
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || pif.vrst)
    begin
      pdata_q  <= 8'h00;
      // idle strobe level for polarity 0, so reset makes no false edge
      prev_q   <= 1'b1;
      cnt_q    <= '0;
      out_q    <= 8'h00;
      oe_q     <= 8'h00;
      hs_out_q <= 1'b1;
      hs_oe_q  <= 1'b0;
      cap_q    <= 1'b0;
    end
    else
    begin
      pdata_q  <= pdata_d;
      prev_q   <= prev_d;
      cnt_q    <= cnt_d;
      out_q    <= out_d;
      oe_q     <= oe_d;
      hs_out_q <= hs_out_d;
      hs_oe_q  <= hs_oe_d;
      cap_q    <= cap_d;
    end
  end

  assign pif.pdata    = pdata_q;
  assign pif.pins_out = out_q;
  assign pif.pins_oe  = oe_q;
  assign pif.hs_out   = hs_out_q;
  assign pif.hs_oe    = hs_oe_q;
  assign pif.cap_evt  = cap_q;

endmodule : epd_port

// File: verilog/epd_top.sv
`timescale 1ns/10ps
module epd_top
  import epd_pkg::*;
#(
  parameter int unsigned LOAD_CYC = LOAD_DELAY_CYC,
  parameter int unsigned PROG_CYC = PROG_TIME_CYC,
  parameter int unsigned PAGE     = PAGE_BYTES,
  parameter int unsigned DEPTH    = ARR_BYTES
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_e_clk,
  input  wire logic       i_addr_strobe,
  input  wire logic       i_chip_en,
  input  wire logic       i_sel_b,
  input  wire logic       i_rw,
  input  wire logic [7:0] i_addr_hi,
  input  wire logic [7:0] i_ad,
  output logic      [7:0] o_ad,
  output logic            o_ad_oe,
  input  wire logic       i_write_gate_in,
  input  wire logic       i_reset_pin,
  input  wire logic [7:0] i_port_a,
  output logic      [7:0] o_port_a,
  output logic      [7:0] o_port_a_oe,
  input  wire logic [7:0] i_port_b,
  output logic      [7:0] o_port_b,
  output logic      [7:0] o_port_b_oe,
  input  wire logic       i_port_a_handshake,
  output logic            o_port_a_handshake,
  output logic            o_port_a_handshake_oe,
  input  wire logic       i_port_b_handshake,
  output logic            o_port_b_handshake,
  output logic            o_port_b_handshake_oe,
  output logic            o_irq_b,
  output logic            o_irq_b_oe
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned PW = $clog2(PAGE);
  localparam int unsigned CW = $clog2(PROG_CYC + 1);

  // ---------------------------------------------------------------
  // window decode
  // ---------------------------------------------------------------
  function automatic logic win_hit(input logic [7:0] hi,
                                   input logic [7:0] map,
                                   input int unsigned bits);
    logic [7:0] m;
    m = 8'hff << (8 - bits);
    return ((hi ^ (map << (8 - bits))) & m) == 8'h00;
  endfunction : win_hit

  // ---------------------------------------------------------------
  // bus capture and read path
  // ---------------------------------------------------------------
  logic        e_q,   e_d;
  logic        as_q,  as_d;
  logic [15:0] addr_q, addr_d;
  logic        sel_q,  sel_d;
  logic        rh_q,   rh_d;
  logic        ah_q,   ah_d;
  logic [7:0]  ad_q,   ad_d;
  logic        ad_oe_q, ad_oe_d;
  logic [7:0]  rd_data;
  logic        live;
  logic        wr_reg;
  logic        wr_arr;
  logic        rd_reg;
  logic        rd_arr;
  logic [9:0]  ofs;
  logic [AW-1:0] aaddr;

  logic [7:0]  rmap_q, rmap_d;
  logic [7:0]  amap_q, amap_d;
  logic [7:0]  setup_q, setup_d;
  logic [3:0]  isr_q,   isr_d;
  logic [7:0]  arr_rd;
  logic [1:0][7:0] pdata;
  logic [1:0]  cap;
  logic        eow_evt;

  assign ofs   = addr_q[9:0];
  assign aaddr = addr_q[AW-1:0];
  assign live  = sel_q && !i_sel_b;
  assign wr_reg = e_q && !i_e_clk && !i_rw && live && rh_q;
  assign wr_arr = e_q && !i_e_clk && !i_rw && live && ah_q;
  assign rd_reg = !e_q && i_e_clk && i_rw && live && rh_q;
  assign rd_arr = !e_q && i_e_clk && i_rw && live && ah_q;

  always_comb
  begin
    e_d    = i_e_clk;
    as_d   = i_addr_strobe;
    addr_d = addr_q;
    sel_d  = sel_q;
    rh_d   = rh_q;
    ah_d   = ah_q;
    if (as_q && !i_addr_strobe && !i_e_clk)
    begin
      addr_d = {i_addr_hi, i_ad};
      sel_d  = i_chip_en && !i_sel_b;
      rh_d   = win_hit(i_addr_hi, rmap_q, 6);
      ah_d   = win_hit(i_addr_hi, amap_q, 3) && !rh_d;
    end
    rd_data = 8'h00;
    if (rh_q)
    begin
      unique case (ofs)
        OFS_REG_MAP: rd_data = ~rmap_q;
        OFS_ARR_MAP: rd_data = ~amap_q;
        OFS_PDATA_A: rd_data = pdata[0];
        OFS_PDATA_B: rd_data = pdata[1];
        OFS_PPIN_A:  rd_data = i_port_a;
        OFS_PPIN_B:  rd_data = i_port_b;
        OFS_SETUP:   rd_data = setup_q;
        OFS_ISR:     rd_data = {4'h0, isr_q};
        default:     rd_data = 8'h00;
      endcase
    end
    else if (ah_q)
    begin
      rd_data = arr_rd;
    end
    ad_d    = rd_data;
    ad_oe_d = live && i_e_clk && i_rw && (rh_q || ah_q);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      e_q     <= 1'b0;
      as_q    <= 1'b0;
      addr_q  <= 16'h0000;
      sel_q   <= 1'b0;
      rh_q    <= 1'b0;
      ah_q    <= 1'b0;
      ad_q    <= 8'h00;
      ad_oe_q <= 1'b0;
    end
    else
    begin
      e_q     <= e_d;
      as_q    <= as_d;
      addr_q  <= addr_d;
      sel_q   <= sel_d;
      rh_q    <= rh_d;
      ah_q    <= ah_d;
      ad_q    <= ad_d;
      ad_oe_q <= ad_oe_d;
    end
  end

  // ---------------------------------------------------------------
  // volatile registers and interrupt pin
  // ---------------------------------------------------------------
  logic vrst;
  logic irq_oe_q, irq_oe_d;
  logic [1:0] clr_int;
  logic       clr_eow;

  // the pin reset leaves the array engine and map registers alone
  assign vrst = amap_q[AM_RST_POL] ? i_reset_pin : !i_reset_pin;

  always_comb
  begin
    setup_d = setup_q;
    if (wr_reg && ofs == OFS_SETUP)
    begin
      setup_d = i_ad;
    end
    clr_int[0] = (wr_reg && ofs == OFS_ISR && !i_ad[0])
              || (rd_reg && ofs == OFS_PDATA_A);
    clr_int[1] = (wr_reg && ofs == OFS_ISR && !i_ad[1])
              || (rd_reg && ofs == OFS_PDATA_B);
    clr_eow    = wr_reg && ofs == OFS_ISR && !i_ad[IS_EOW];
    // a capture or a finished write in the clearing cycle still counts
    isr_d[0] = cap[0] || (isr_q[0] && !clr_int[0]);
    isr_d[1] = cap[1] || (isr_q[1] && !clr_int[1]);
    isr_d[IS_EOW] = eow_evt || (isr_q[IS_EOW] && !clr_eow);
    isr_d[IS_EOW_EN] = (wr_reg && ofs == OFS_ISR) ? i_ad[IS_EOW_EN]
                                                  : isr_q[IS_EOW_EN];
    irq_oe_d = (isr_q[0] && setup_q[SU_IEN])
            || (isr_q[1] && setup_q[SU_IEN + 1])
            || (isr_q[IS_EOW] && isr_q[IS_EOW_EN]);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || vrst)
    begin
      setup_q  <= SETUP_RST;
      isr_q    <= ISR_RST;
      irq_oe_q <= 1'b0;
    end
    else
    begin
      setup_q  <= setup_d;
      isr_q    <= isr_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  // ---------------------------------------------------------------
  // ports
  // ---------------------------------------------------------------
  logic [1:0][7:0] pin_in;
  logic [1:0]      hs_in;

  assign pin_in = {i_port_b, i_port_a};
  assign hs_in  = {i_port_b_handshake, i_port_a_handshake};

  epd_port_if pif [2] ();

  for (genvar k = 0; k < 2; k++)
  begin : g_port
    assign pif[k].dir        = setup_q[SU_DIR + k];
    assign pif[k].open_drain = setup_q[SU_OD + k];
    assign pif[k].pol        = setup_q[SU_POL + k];
    assign pif[k].wr         = wr_reg && ofs == (OFS_PDATA_A + 10'(k));
    assign pif[k].vrst       = vrst;
    assign pif[k].echo       = (k == 1) && amap_q[AM_ECHO];
    assign pif[k].wdata      = i_ad;
    assign pif[k].echo_addr  = addr_q[7:0];
    assign pif[k].pins_in    = pin_in[k];
    assign pif[k].hs_in      = hs_in[k];
    assign pdata[k]          = pif[k].pdata;
    assign cap[k]            = pif[k].cap_evt;

    epd_port u_port (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .pif     (pif[k])
    );
  end

  // ---------------------------------------------------------------
  // nonvolatile write engine
  // ---------------------------------------------------------------
  logic [7:0]       mem  [DEPTH];
  logic [7:0]       pbuf [PAGE];
  epd_pgm_t         st_q,    st_d;
  epd_seq_t         seq_q,   seq_d;
  epd_arm_t         arm_q,   arm_d;
  logic [CW-1:0]    tmr_q,   tmr_d;
  logic [AW-PW-1:0] page_q,  page_d;
  logic [PAGE-1:0]  pval_q,  pval_d;
  logic             tog_q,   tog_d;
  logic             plane_q, plane_d;
  logic             open_q,  open_d;
  logic             guard_q, guard_d;
  logic [7:0]       lock_q,  lock_d;
  logic             take;
  logic             acc;
  logic             commit;
  logic             gate_ok;

  assign gate_ok = !i_write_gate_in;
  assign eow_evt = commit;

  always_comb
  begin
    arr_rd = mem[aaddr];
    if (st_q == PG_PROG && aaddr[AW-1] == plane_q)
    begin
      arr_rd[6] = tog_q;
    end
  end

  always_comb
  begin
    st_d = st_q;  seq_d = seq_q;  arm_d = arm_q;  tmr_d = tmr_q;
    page_d = page_q;  pval_d = pval_q;  tog_d = tog_q;
    plane_d = plane_q;  open_d = open_q;  guard_d = guard_q;
    lock_d = lock_q;  rmap_d = rmap_q;  amap_d = amap_q;
    take = 1'b0;
    commit = 1'b0;
    if (wr_arr)
    begin
      seq_d = SQ_IDLE;
      unique case (seq_q)
        SQ_IDLE, SQ_TWO:
          if (aaddr == CMD_ADDR1 && i_ad == CMD_B1 && seq_q == SQ_IDLE)
          begin
            seq_d = SQ_ONE;
            take  = 1'b1;
          end
          else if (aaddr == CMD_ADDR1 && i_ad == CMD_WR_EN
                   && seq_q == SQ_TWO)
          begin
            open_d = 1'b1;
            take   = 1'b1;
          end
          else if (aaddr == CMD_ADDR1 && i_ad == CMD_EXT
                   && seq_q == SQ_TWO)
          begin
            seq_d = SQ_THREE;
            take  = 1'b1;
          end
        SQ_ONE:
          if (aaddr == CMD_ADDR2 && i_ad == CMD_B2)
          begin
            seq_d = SQ_TWO;
            take  = 1'b1;
          end
        SQ_THREE:
          if (aaddr == CMD_ADDR1 && i_ad == CMD_B1)
          begin
            seq_d = SQ_FOUR;
            take  = 1'b1;
          end
        SQ_FOUR:
          if (aaddr == CMD_ADDR2)
          begin
            take = 1'b1;
            unique case (i_ad)
              CMD_GUARD_OFF: guard_d = 1'b0;
              CMD_LOCK:      arm_d   = ARM_LOCK;
              CMD_RMAP:      arm_d   = ARM_RMAP;
              CMD_AMAP:      arm_d   = ARM_AMAP;
              default:       take    = 1'b0;
            endcase
          end
        default: seq_d = SQ_IDLE;
      endcase
    end
    unique case (st_q)
      PG_IDLE: ;
      PG_LOAD:
        if (!gate_ok)
        begin
          st_d   = PG_IDLE;
          pval_d = '0;
          open_d = 1'b0;
        end
        else if (tmr_q == '0)
        begin
          st_d    = PG_PROG;
          tmr_d   = CW'(PROG_CYC - 1);
          plane_d = page_q[AW-PW-1];
        end
        else
        begin
          tmr_d = tmr_q - 1'b1;
        end
      PG_PROG:
      begin
        if (rd_arr && aaddr[AW-1] == plane_q)
        begin
          tog_d = !tog_q;
        end
        if (tmr_q == '0)
        begin
          commit = 1'b1;
          st_d   = PG_IDLE;
          pval_d = '0;
          open_d = 1'b0;
        end
        else
        begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      default: st_d = PG_IDLE;
    endcase
    acc = wr_arr && !take && gate_ok && st_q != PG_PROG
       && arm_q != ARM_LOCK
       && !lock_q[aaddr[AW-1 -: 3]]
       && (!guard_q || open_q)
       && (st_q == PG_IDLE || aaddr[AW-1:PW] == page_q);
    if (wr_arr && !take && gate_ok && arm_q == ARM_LOCK)
    begin
      lock_d  = i_ad;
      arm_d   = ARM_NONE;
      guard_d = 1'b1;
    end
    else if (acc)
    begin
      st_d   = PG_LOAD;
      tmr_d  = CW'(LOAD_CYC - 1);
      page_d = aaddr[AW-1:PW];
      pval_d[aaddr[PW-1:0]] = 1'b1;
    end
    if (wr_reg && gate_ok && ofs == OFS_REG_MAP && arm_q == ARM_RMAP)
    begin
      rmap_d  = i_ad;
      arm_d   = ARM_NONE;
      guard_d = 1'b1;
    end
    if (wr_reg && gate_ok && ofs == OFS_ARR_MAP && arm_q == ARM_AMAP)
    begin
      amap_d  = i_ad & ARR_MAP_MASK;
      arm_d   = ARM_NONE;
      guard_d = 1'b1;
    end
  end

  // nonvolatile state survives the pin reset; only power-on clears it
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      st_q    <= PG_IDLE;
      seq_q   <= SQ_IDLE;
      arm_q   <= ARM_NONE;
      tmr_q   <= '0;
      page_q  <= '0;
      pval_q  <= '0;
      tog_q   <= 1'b0;
      plane_q <= 1'b0;
      open_q  <= 1'b0;
      guard_q <= 1'b1;
      lock_q  <= LOCK_RST;
      rmap_q  <= REG_MAP_RST;
      amap_q  <= ARR_MAP_RST;
    end
    else
    begin
      st_q    <= st_d;
      seq_q   <= seq_d;
      arm_q   <= arm_d;
      tmr_q   <= tmr_d;
      page_q  <= page_d;
      pval_q  <= pval_d;
      tog_q   <= tog_d;
      plane_q <= plane_d;
      open_q  <= open_d;
      guard_q <= guard_d;
      lock_q  <= lock_d;
      rmap_q  <= rmap_d;
      amap_q  <= amap_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (acc)
    begin
      pbuf[aaddr[PW-1:0]] <= i_ad;
    end
    if (commit)
    begin
      for (int i = 0; i < PAGE; i++)
      begin
        if (pval_q[i])
        begin
          mem[{page_q, PW'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign o_ad                  = ad_q;
  assign o_ad_oe               = ad_oe_q;
  assign o_port_a              = pif[0].pins_out;
  assign o_port_a_oe           = pif[0].pins_oe;
  assign o_port_b              = pif[1].pins_out;
  assign o_port_b_oe           = pif[1].pins_oe;
  assign o_port_a_handshake    = pif[0].hs_out;
  assign o_port_a_handshake_oe = pif[0].hs_oe;
  assign o_port_b_handshake    = pif[1].hs_out;
  assign o_port_b_handshake_oe = pif[1].hs_oe;
  assign o_irq_b_oe            = irq_oe_q;
  assign o_irq_b               = 1'b0;

endmodule : epd_top

// File: bench/epd_chk.sv
`timescale 1ns/10ps
module epd_chk (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_e_clk,
  input wire logic       i_sel_b,
  input wire logic       i_rw,
  input wire logic       o_ad_oe,
  input wire logic [7:0] o_port_a,
  input wire logic [7:0] o_port_a_oe,
  input wire logic       o_port_a_handshake,
  input wire logic       o_port_a_handshake_oe,
  input wire logic       o_irq_b
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_read_cause:
  assert property (o_ad_oe |-> $past(i_e_clk) && $past(i_rw))
    else $error("read drive without read phase");
  a_read_release:
  assert property (!i_e_clk |=> !o_ad_oe) else $error("read drive held");
  a_read_hold:
  assert property (i_e_clk && i_rw && o_ad_oe |=> o_ad_oe)
    else $error("read drive dropped early");
  a_read_select:
  assert property ($rose(o_ad_oe) |-> !$past(i_sel_b))
    else $error("drive while deselected");
  a_irq_level:
  assert property (o_irq_b == 1'b0) else $error("irq driven high");
  a_pulse_len:
  assert property ($fell(o_port_a_handshake) |-> !o_port_a_handshake[*8]
    ##1 !o_port_a_handshake ##1 !o_port_a_handshake ##1 o_port_a_handshake)
    else $error("strobe pulse length wrong");
  a_pulse_drive:
  assert property ($fell(o_port_a_handshake) |-> o_port_a_handshake_oe)
    else $error("strobe pulse undriven");
  a_data_pulse:
  assert property ($changed(o_port_a) && o_port_a_oe != 8'h00
    && $past(o_port_a_oe) != 8'h00 |-> $fell(o_port_a_handshake))
    else $error("port data moved without pulse");
endmodule : epd_chk
bind epd_top epd_chk i_chk (.i_clk, .i_rst_b, .i_e_clk, .i_sel_b, .i_rw,
  .o_ad_oe, .o_port_a, .o_port_a_oe, .o_port_a_handshake,
  .o_port_a_handshake_oe, .o_irq_b);

// File: bench/epd_mcu.sv
`timescale 1ns/10ps
module epd_mcu (
  input  wire logic        i_clk,
  input  wire logic        i_ad_oe,
  input  wire logic [7:0]  i_ad_dev,
  output logic             o_e = 1'b0,
  output logic             o_as = 1'b0,
  output logic             o_rw = 1'b1,
  output logic      [15:0] o_addr = 16'h0000,
  output logic      [7:0]  o_ad
);
  logic [7:0] drv_q = 8'h00;
  // released bus shows a moving pattern, never the last value
  assign o_ad = i_ad_oe ? i_ad_dev : drv_q;
  task automatic cyc(input logic rw, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge i_clk);
    o_as = 1'b1;
    o_addr = a;
    drv_q = a[7:0];
    o_rw = rw;
    @(negedge i_clk);
    o_as = 1'b0;
    repeat (2) @(negedge i_clk);
    o_e = 1'b1;
    drv_q = rw ? ~drv_q : d;
    repeat (4) @(negedge i_clk);
    o_e = 1'b0;
    @(negedge i_clk);
    drv_q = ~drv_q;
  endtask : cyc
endmodule : epd_mcu

// File: bench/test_epd_top.sv
`timescale 1ns/10ps
module test_epd_top;
  import epd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rst_pin = 1'b1;
  logic        sel_b = 1'b0;
  logic        gate = 1'b0;
  logic        e, as, rw, ad_oe, oe_q, b, irq;
  logic        hs_a = 1'b1;
  logic [7:0]  pa_in = 8'h00;
  logic [15:0] addr;
  logic [7:0]  ad, ad_dev, pa, pa_oe, d, last;
  logic [7:0]  exp_q[$];
  int          failures = 0;
  int          tests_run = 0;
  int          seed = 32'h2f1c;
  always #5 clk = ~clk;
  epd_mcu i_mcu (.i_clk(clk), .i_ad_oe(ad_oe), .i_ad_dev(ad_dev),
    .o_e(e), .o_as(as), .o_rw(rw), .o_addr(addr), .o_ad(ad));
  epd_top #(.LOAD_CYC(20), .PROG_CYC(50)) i_dut (.i_clk(clk),
    .i_rst_b(rst_b), .i_e_clk(e), .i_addr_strobe(as), .i_chip_en(1'b1),
    .i_sel_b(sel_b), .i_rw(rw), .i_addr_hi(addr[15:8]), .i_ad(ad),
    .o_ad(ad_dev), .o_ad_oe(ad_oe), .i_write_gate_in(gate),
    .i_reset_pin(rst_pin), .i_port_a(pa_in), .o_port_a(pa),
    .o_port_a_oe(pa_oe), .i_port_b(8'h00), .o_port_b(), .o_port_b_oe(),
    .i_port_a_handshake(hs_a), .o_port_a_handshake(),
    .o_port_a_handshake_oe(), .i_port_b_handshake(1'b1),
    .o_port_b_handshake(), .o_port_b_handshake_oe(), .o_irq_b(),
    .o_irq_b_oe(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    i_mcu.cyc(1'b0, a, v);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_mcu.cyc(1'b1, a, 8'h00);
  endtask : rd
  task automatic unlock();
    wr({3'h7, CMD_ADDR1}, CMD_B1);
    wr({3'h7, CMD_ADDR2}, CMD_B2);
    wr({3'h7, CMD_ADDR1}, CMD_WR_EN);
  endtask : unlock
  always @(posedge clk)
  begin
    oe_q <= ad_oe;
    if (ad_oe && !oe_q)
    begin
      last <= ad_dev;
      if (exp_q.size() != 0)
        chk(ad_dev, exp_q.pop_front(), "read data");
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    rd(16'h0400, ~REG_MAP_RST);
    rd(16'h0438, ~ARR_MAP_RST);
    wr(16'h0408, 8'h01);
    d = 8'($random(seed));
    wr(16'h0404, d);
    @(negedge clk);
    chk(pa, d, "port a data");
    unlock();
    wr(16'he010, d);
    repeat (25) @(negedge clk);
    i_mcu.cyc(1'b1, 16'he010, 8'h00);
    b = last[6];
    i_mcu.cyc(1'b1, 16'he010, 8'h00);
    chk({7'h00, last[6]}, {7'h00, ~b}, "poll bit");
    repeat (60) @(negedge clk);
    rd(16'he010, d);
    wr(16'he010, ~d);
    repeat (100) @(negedge clk);
    rd(16'he010, d);
    unlock();
    wr(16'he010, ~d);
    gate = 1'b1;
    @(negedge clk);
    gate = 1'b0;
    repeat (100) @(negedge clk);
    rd(16'he010, d);
    rst_pin = 1'b0;
    repeat (2) @(negedge clk);
    rst_pin = 1'b1;
    chk(pa_oe, 8'h00, "port a drive");
    rd(16'h0438, ~ARR_MAP_RST);
    sel_b = 1'b1;
    wr(16'h0408, 8'h01);
    sel_b = 1'b0;
    rd(16'h0408, SETUP_RST);
    wr(16'h0408, 8'h40);
    d = 8'($random(seed));
    pa_in = d;
    hs_a = 1'b0;
    @(negedge clk);
    hs_a = 1'b1;
    repeat (3) @(negedge clk);
    pa_in = ~d;
    chk({7'h00, irq}, 8'h01, "irq drive");
    rd(16'h0404, d);
    chk({7'h00, irq}, 8'h00, "irq release");
    wr({3'h7, CMD_ADDR1}, CMD_B1);
    wr({3'h7, CMD_ADDR2}, CMD_B2);
    wr({3'h7, CMD_ADDR1}, CMD_EXT);
    wr({3'h7, CMD_ADDR1}, CMD_B1);
    wr({3'h7, CMD_ADDR2}, CMD_RMAP);
    wr(16'h0400, 8'h82);
    rd(16'h0800, ~8'h82);
    repeat (5) @(negedge clk);
    chk(8'(exp_q.size()), 8'h00, "pending reads");
    final_report();
  end
  initial
  begin
    // the sequence needs under 1000 cycles
    #50us;
    failures++;
    final_report();
  end
  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
endmodule : test_epd_top
